// >>> logic/pef_event_flags.v
// latched per-channel event flags of a four-channel powered-ethernet group
// Functional notes
// - each event register has a plain view code and a clear-on-read code
// - a channel switched off loses its flags in all three registers
// - clear-on-read of the alerting register releases the alert output
// - any set flag raises its summary bit
// - detection register: class events high nibble, detect events low nibble
// - class flag on every class cycle, or only on class change
// - detect flag on every detect cycle, or only on outcome change
// - four-pair detection without pending power-on waits for both channels, unless dual-signature in auto mode
// - four-pair detect flags of both channels set together
// - single-signature four-pair: class flag only on the classified channel
// - dual-signature discovery: semi-auto pairs class flags, manual is per channel
// - dual-signature with pending power-on or auto mode: flags per channel
// - fault register: disconnect high nibble, overload cut low nibble
// - four-pair overload flags update per channel
// - single-signature disconnect sets both channels, dual per channel
// - host may re-power a dual-signature channel after a cut
// - overload cut disabled keeps power yet still flags after timeout
// - clearing an overload flag leaves the timing counters alone
// - limit flag after holding current limit beyond limit timeout
// - start register low nibble: start timeout or class/detect error
// - alert needs mask bit and global enable, flags latch regardless
//
// Register access over Avalon-MM was decided locally.
`include "pef_defs.vh"
`default_nettype none
module pef_event_flags #(
    parameter CLK_HZ = `PEF_CLK_HZ,
    parameter OVLD_US = `PEF_OVLD_US,
    parameter LIM_US = `PEF_LIM_US
) (
    input wire clk,
    input wire nrst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire [3:0] detectDone,
    input wire [3:0] detectValid,
    input wire [3:0] classDone,
    input wire [15:0] classValue,
    input wire [3:0] disconnect,
    input wire [3:0] overCurrent,
    input wire [3:0] inLimit,
    input wire [3:0] startFault,
    input wire [3:0] channelOff,
    input wire [1:0] powerOnRequest,
    output reg alertN,
    output reg [4:0] intSummary,
    output reg [3:0] overloadCutReq
);

// cycle counts are worked out at full integer width, then cut to the counter width on purpose
localparam integer OVLD_TOT = OVLD_US * (CLK_HZ / `PEF_HZ_PER_MHZ);
localparam integer LIM_TOT = LIM_US * (CLK_HZ / `PEF_HZ_PER_MHZ);
// the fire compare sits one below the saturating count so each episode flags once
localparam [`PEF_CNT_W-1:0] OVLD_CYC = OVLD_TOT[`PEF_CNT_W-1:0];
localparam [`PEF_CNT_W-1:0] LIM_CYC = LIM_TOT[`PEF_CNT_W-1:0];

////////////////////////////////////////////////////////////////////////
// registers and control decode

reg [7:0] detFlags_r;
reg [7:0] fltFlags_r;
reg [7:0] stlFlags_r;
reg [31:0] ctrl_r;
wire [3:0] prevDet;
wire [15:0] prevCls;
reg [3:0] detDoneH_r;
reg [3:0] detEvtH_r;
reg [3:0] clsDoneH_r;
reg [3:0] clsEvtH_r;

wire [4:0] mask = ctrl_r[`PEF_MSK_HI:`PEF_MSK_LO];
wire clsChg = ctrl_r[`PEF_CTRL_CLCH];
wire detChg = ctrl_r[`PEF_CTRL_DECH];
wire glbEn = ctrl_r[`PEF_CTRL_GEN];
wire [1:0] mode = ctrl_r[`PEF_CTRL_MODE_HI:`PEF_CTRL_MODE_LO];
wire [1:0] fourPair = ctrl_r[`PEF_CTRL_4P_HI:`PEF_CTRL_4P_LO];
wire [1:0] dualSig = ctrl_r[`PEF_CTRL_DS_HI:`PEF_CTRL_DS_LO];
wire [3:0] noCut = ctrl_r[`PEF_CTRL_NOCUT_HI:`PEF_CTRL_NOCUT_LO];
wire autoMode = (mode == `PEF_MODE_AUTO);
wire semiMode = (mode == `PEF_MODE_SEMI);

////////////////////////////////////////////////////////////////////////
// raw per-channel events

wire [3:0] detEvt;
wire [3:0] clsEvt;
wire [3:0] ovlFire;
wire [3:0] limFire;

// change-only mode compares against the last outcome of the channel
assign detEvt = detectDone & (~{4{detChg}} | (detectValid ^ prevDet));

genvar c;
generate
    for (c = 0; c < 4; c = c + 1) begin : gCh
        wire [3:0] clsNow = classValue[4*c+3:4*c];
        wire [3:0] clsOld = prevCls[4*c+3:4*c];
        reg [`PEF_CNT_W-1:0] ovlCnt_r;
        reg [`PEF_CNT_W-1:0] limCnt_r;
        assign clsEvt[c] = classDone[c] & (~clsChg | (clsNow != clsOld));
        // counters run on the live condition only; flag clears never touch them
        assign ovlFire[c] = overCurrent[c] & (ovlCnt_r == OVLD_CYC - 1'b1);
        assign limFire[c] = inLimit[c] & (limCnt_r == LIM_CYC - 1'b1);
        always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                ovlCnt_r <= {`PEF_CNT_W{1'b0}};
                limCnt_r <= {`PEF_CNT_W{1'b0}};
            end else begin
                if (!overCurrent[c] || channelOff[c]) begin
                    ovlCnt_r <= {`PEF_CNT_W{1'b0}};
                end else if (ovlCnt_r != OVLD_CYC) begin
                    ovlCnt_r <= ovlCnt_r + 1'b1;
                end
                if (!inLimit[c] || channelOff[c]) begin
                    limCnt_r <= {`PEF_CNT_W{1'b0}};
                end else if (limCnt_r != LIM_CYC) begin
                    limCnt_r <= limCnt_r + 1'b1;
                end
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// four-pair pairing of discovery and disconnect events

wire [3:0] detSet;
wire [3:0] clsSet;
wire [3:0] disSet;
wire [3:0] detDoneHN;
wire [3:0] detEvtHN;
wire [3:0] clsDoneHN;
wire [3:0] clsEvtHN;

genvar p;
generate
    for (p = 0; p < 2; p = p + 1) begin : gPort
        wire [1:0] pc = {channelOff[2*p+1], channelOff[2*p]};
        wire fp = fourPair[p];
        wire pend = powerOnRequest[p];
        wire dual = dualSig[p];
        // dual signature with pending power-on or auto runs each channel alone
        wire detPair = fp & ~pend & ~(dual & autoMode);
        wire clsPair = fp & dual & ~pend & semiMode;
        wire [1:0] dDone = detDoneH_r[2*p+1:2*p] | detectDone[2*p+1:2*p];
        wire [1:0] dEvt = detEvtH_r[2*p+1:2*p] | detEvt[2*p+1:2*p];
        wire [1:0] cDone = clsDoneH_r[2*p+1:2*p] | classDone[2*p+1:2*p];
        wire [1:0] cEvt = clsEvtH_r[2*p+1:2*p] | clsEvt[2*p+1:2*p];
        wire dBoth = &dDone;
        wire cBoth = &cDone;
        wire dKeep = detPair & ~dBoth & ~(|pc);
        wire cKeep = clsPair & ~cBoth & ~(|pc);
        // both detect flags land in the same cycle, once the second channel has completed
        assign detSet[2*p+1:2*p] = detPair ? (dEvt & {2{dBoth}}) :
            detEvt[2*p+1:2*p];
        // single signature passes through: only the classified channel reports
        assign clsSet[2*p+1:2*p] = clsPair ? (cEvt & {2{cBoth}}) :
            clsEvt[2*p+1:2*p];
        assign detDoneHN[2*p+1:2*p] = dKeep ? dDone : 2'h0;
        assign detEvtHN[2*p+1:2*p] = dKeep ? dEvt : 2'h0;
        assign clsDoneHN[2*p+1:2*p] = cKeep ? cDone : 2'h0;
        assign clsEvtHN[2*p+1:2*p] = cKeep ? cEvt : 2'h0;
        assign disSet[2*p] = disconnect[2*p] |
            (fp & ~dual & disconnect[2*p+1]);
        assign disSet[2*p+1] = disconnect[2*p+1] |
            (fp & ~dual & disconnect[2*p]);
    end
endgenerate

////////////////////////////////////////////////////////////////////////
// bus decode

function [31:0] rdMux;
    input [5:0] idx;
    input [7:0] det;
    input [7:0] flt;
    input [7:0] stl;
    input [31:0] ctl;
    input [5:0] stat;
    begin
        case (idx)
            `PEF_IDX_DET_VIEW, `PEF_IDX_DET_CLR: rdMux = {24'h000000, det};
            `PEF_IDX_FLT_VIEW, `PEF_IDX_FLT_CLR: rdMux = {24'h000000, flt};
            `PEF_IDX_STL_VIEW, `PEF_IDX_STL_CLR: rdMux = {24'h000000, stl};
            `PEF_IDX_CTRL: rdMux = ctl & `PEF_CTRL_WMASK;
            `PEF_IDX_STAT: rdMux = {26'h0000000, stat};
            default: rdMux = 32'h00000000;
        endcase
    end
endfunction

function isIdx;
    input [7:0] addr;
    input [5:0] idx;
    begin
        isIdx = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
    end
endfunction

// read wins when both strobes are high; the master never does that on purpose
wire take = (avs_read | avs_write) & avs_waitrequest;
wire rdTake = take & avs_read;
wire wrTake = take & avs_write & ~avs_read;
wire aligned = (avs_address[1:0] == 2'h0);
wire [5:0] idx = avs_address[7:2];
// unaligned addresses never hit a register
wire wrCtrl = wrTake & isIdx(avs_address, `PEF_IDX_CTRL);
wire [31:0] ctrlWm = `PEF_CTRL_WMASK;
wire [31:0] ctrlNxt;

// each byte lane is written alone; bits outside the writable mask stay zero
genvar b;
generate
    for (b = 0; b < 4; b = b + 1) begin : gLane
        wire [7:0] wm = ctrlWm[8*b+7:8*b];
        wire [7:0] cur = ctrl_r[8*b+7:8*b];
        wire [7:0] wd = avs_writedata[8*b+7:8*b];
        assign ctrlNxt[8*b+7:8*b] = avs_byteenable[b] ? ((cur & ~wm) | (wd & wm)) : cur;
    end
endgenerate

// picks the returned flags for a clear-on-read, nothing otherwise
function [7:0] clrPick;
    input hit;
    input [7:0] flags;
    begin
        clrPick = hit ? flags : `PEF_FLAG_RST;
    end
endfunction

wire rdDetClr = rdTake && isIdx(avs_address, `PEF_IDX_DET_CLR);
wire rdFltClr = rdTake && isIdx(avs_address, `PEF_IDX_FLT_CLR);
wire rdStlClr = rdTake && isIdx(avs_address, `PEF_IDX_STL_CLR);
// only the bits that go out on the bus are cleared; a set in the same cycle wins
wire [7:0] clrDet = clrPick(rdDetClr, detFlags_r);
wire [7:0] clrFlt = clrPick(rdFltClr, fltFlags_r);
wire [7:0] clrStl = clrPick(rdStlClr, stlFlags_r);

////////////////////////////////////////////////////////////////////////
// flag update

wire [7:0] detNxt;
wire [7:0] fltNxt;
wire [7:0] stlNxt;

// per-channel next values: clear the returned bits, add new events, then apply off
genvar f;
generate
    for (f = 0; f < 4; f = f + 1) begin : gFlag
        // a channel that is off holds no events; off beats a set in the same cycle
        wire keep = ~channelOff[f];
        assign detNxt[f] = ((detFlags_r[f] & ~clrDet[f]) | detSet[f]) & keep;
        assign detNxt[f+4] = ((detFlags_r[f+4] & ~clrDet[f+4]) | clsSet[f]) & keep;
        assign fltNxt[f] = ((fltFlags_r[f] & ~clrFlt[f]) | ovlFire[f]) & keep;
        assign fltNxt[f+4] = ((fltFlags_r[f+4] & ~clrFlt[f+4]) | disSet[f]) & keep;
        assign stlNxt[f] = ((stlFlags_r[f] & ~clrStl[f]) | startFault[f]) & keep;
        assign stlNxt[f+4] = ((stlFlags_r[f+4] & ~clrStl[f+4]) | limFire[f]) & keep;
    end
endgenerate

// summary follows the flags, whatever the mask says
wire [4:0] sumNxt;
assign sumNxt[`PEF_SUM_DIS] = |fltNxt[7:4];
assign sumNxt[`PEF_SUM_DET] = |detNxt[3:0];
assign sumNxt[`PEF_SUM_CLS] = |detNxt[7:4];
assign sumNxt[`PEF_SUM_OVL] = |fltNxt[3:0] | |stlNxt[7:4];
assign sumNxt[`PEF_SUM_STR] = |stlNxt[3:0];
wire alertNxt = glbEn & |(sumNxt & mask);

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        detFlags_r <= `PEF_FLAG_RST;
        fltFlags_r <= `PEF_FLAG_RST;
        stlFlags_r <= `PEF_FLAG_RST;
        intSummary <= 5'h00;
        alertN <= 1'b1;
        overloadCutReq <= 4'h0;
    end else begin
        detFlags_r <= detNxt;
        fltFlags_r <= fltNxt;
        stlFlags_r <= stlNxt;
        intSummary <= sumNxt;
        alertN <= ~alertNxt;
        // with the cut disabled the channel stays up; the flag still latches
        overloadCutReq <= ovlFire & ~noCut;
    end
end

////////////////////////////////////////////////////////////////////////
// discovery history and pairing holds

genvar h;
generate
    for (h = 0; h < 4; h = h + 1) begin : gHist
        reg detOld_r;
        reg [3:0] clsOld_r;
        // change-only compares against this channel's own last outcome
        assign prevDet[h] = detOld_r;
        assign prevCls[4*h+3:4*h] = clsOld_r;
        always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                detOld_r <= 1'b0;
                clsOld_r <= 4'h0;
            end else begin
                if (detectDone[h]) begin
                    detOld_r <= detectValid[h];
                end
                if (classDone[h]) begin
                    clsOld_r <= classValue[4*h+3:4*h];
                end
            end
        end
    end
endgenerate

// pairing holds drop as soon as the pair completes or a channel goes off
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        detDoneH_r <= 4'h0;
        detEvtH_r <= 4'h0;
        clsDoneH_r <= 4'h0;
        clsEvtH_r <= 4'h0;
    end else begin
        detDoneH_r <= detDoneHN;
        detEvtH_r <= detEvtHN;
        clsDoneH_r <= clsDoneHN;
        clsEvtH_r <= clsEvtHN;
    end
end

////////////////////////////////////////////////////////////////////////
// avalon slave: one wait cycle, answer on the following edge

// status reads the alert as it stands on the pin, not its next value
wire [5:0] statWord = {~alertN, intSummary};

always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        avs_waitrequest <= 1'b1;
    end else begin
        // low for exactly the one cycle after a taken request
        avs_waitrequest <= ~take;
    end
end

// read data stands until the next taken request; a taken write loads zero
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        avs_readdata <= 32'h00000000;
    end else if (take) begin
        avs_readdata <= (avs_read && aligned) ?
            rdMux(idx, detFlags_r, fltFlags_r, stlFlags_r, ctrl_r, statWord) : 32'h00000000;
    end
end

// control bits outside the writable mask never set
always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
        ctrl_r <= `PEF_CTRL_RST;
    end else if (wrCtrl) begin
        // power-on after a single-channel cut is the host's move via control
        ctrl_r <= ctrlNxt;
    end
end

endmodule
`default_nettype wire

// >>> logic/pef_defs.vh
// register map, field positions and reset values of the port event flag bank
`ifndef PEF_DEFS_VH
`define PEF_DEFS_VH
// register indices, byte address is index times four
`define PEF_IDX_DET_VIEW 6'h04
`define PEF_IDX_DET_CLR 6'h05
`define PEF_IDX_FLT_VIEW 6'h06
`define PEF_IDX_FLT_CLR 6'h07
`define PEF_IDX_STL_VIEW 6'h08
`define PEF_IDX_STL_CLR 6'h09
`define PEF_IDX_CTRL 6'h10
`define PEF_IDX_STAT 6'h11
`define PEF_FLAG_RST 8'h00
// control register layout
`define PEF_CTRL_RST 32'h00000000
`define PEF_CTRL_WMASK 32'h000f3fff
`define PEF_MSK_LO 0
`define PEF_MSK_HI 4
`define PEF_CTRL_CLCH 5
`define PEF_CTRL_DECH 6
`define PEF_CTRL_GEN 7
`define PEF_CTRL_MODE_LO 8
`define PEF_CTRL_MODE_HI 9
`define PEF_CTRL_4P_LO 10
`define PEF_CTRL_4P_HI 11
`define PEF_CTRL_DS_LO 12
`define PEF_CTRL_DS_HI 13
`define PEF_CTRL_NOCUT_LO 16
`define PEF_CTRL_NOCUT_HI 19
// summary bit positions, same order as the mask bits
`define PEF_SUM_DIS 0
`define PEF_SUM_DET 1
`define PEF_SUM_CLS 2
`define PEF_SUM_OVL 3
`define PEF_SUM_STR 4
`define PEF_STAT_ALERT 5
// operating modes
`define PEF_MODE_MANUAL 2'h0
`define PEF_MODE_SEMI 2'h1
`define PEF_MODE_AUTO 2'h3
// timing defaults
`define PEF_OVLD_US 50000
`define PEF_LIM_US 50000
`define PEF_CLK_HZ 20000000
`define PEF_HZ_PER_MHZ 1000000
`define PEF_CNT_W 24
`endif

// >>> bench/pef_event_flags_props.sv
// checker for the event flag bank ports
`default_nettype none
module pef_event_flags_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [3:0] disconnect,
    input wire logic [3:0] overCurrent,
    input wire logic [3:0] startFault,
    input wire logic [3:0] channelOff,
    input wire logic alertN,
    input wire logic [4:0] intSummary,
    input wire logic [3:0] overloadCutReq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_idle: assert property (avs_waitrequest && !avs_read && !avs_write |=> avs_waitrequest)
        else $error("answer without a request");
    a_alert_quiet: assert property (intSummary == 5'h00 |-> alertN)
        else $error("alert active with no summary bit");
    a_off_clears: assert property (channelOff == 4'hf |=> intSummary == 5'h00)
        else $error("flags survive channel off");
    a_start_sum: assert property (startFault[0] && !channelOff[0] |=> intSummary[4])
        else $error("start fault not summarised");
    a_disc_sum: assert property (disconnect[3] && !channelOff[3] |=> intSummary[0])
        else $error("disconnect not summarised");
    a_cut_cause: assert property (overloadCutReq[1] |-> $past(overCurrent[1]) && $past(overCurrent[1], 2))
        else $error("cut without sustained overload");
    a_sum_hold: assert property ($fell(intSummary[0]) |-> $past(avs_read) || $past(|channelOff))
        else $error("summary dropped without clear or channel off");
endmodule
bind pef_event_flags pef_event_flags_props chk (.clk(clk), .nrst(nrst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .disconnect(disconnect),
    .overCurrent(overCurrent), .startFault(startFault), .channelOff(channelOff), .alertN(alertN),
    .intSummary(intSummary), .overloadCutReq(overloadCutReq));
`default_nettype wire

// >>> bench/pef_host.sv
// host controller model: bus master reaching the event registers
`default_nettype none
module pef_host (
    input wire logic clk,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        avs_address = 8'hff;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'hffffffff;
    end
    // view and clear codes share one access path, only the address differs
    task access(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !w;
        avs_write <= w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // released lines show inverted values so stale data is never mistaken
        avs_address <= ~a;
        avs_writedata <= ~wd;
        // let one edge pass so a following call never re-drives in this time step
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> bench/pef_event_flags_tb_top.sv
// self-checking bench for the event flag bank
`default_nettype none
module pef_event_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0;
    logic [7:0] adr;
    logic rdS, wrS, waitS, alertN;
    logic [31:0] wdat, rdat, d;
    logic [3:0] detDone = 4'h0, detValid = 4'h0, clsDone = 4'h0, disc = 4'h0;
    logic [3:0] ovc = 4'h0, lim = 4'h0, stf = 4'h0, off = 4'h0, cut;
    logic [15:0] clsVal = 16'h0000;
    logic [4:0] sum;
    logic [1:0] pon = 2'h0;
    int err_total = 0, n_checks = 0;
    int cutSeen = 0;
    always @(posedge clk) begin
        if (cut[1] === 1'b1) cutSeen <= cutSeen + 1;
    end
    pef_event_flags #(.OVLD_US(2), .LIM_US(2)) dut (.clk(clk), .nrst(nrst), .avs_address(adr), .avs_read(rdS),
        .avs_write(wrS), .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
        .avs_waitrequest(waitS), .detectDone(detDone), .detectValid(detValid), .classDone(clsDone),
        .classValue(clsVal), .disconnect(disc), .overCurrent(ovc), .inLimit(lim), .startFault(stf),
        .channelOff(off), .powerOnRequest(pon), .alertN(alertN), .intSummary(sum), .overloadCutReq(cut));
    pef_host host (.clk(clk), .avs_readdata(rdat), .avs_waitrequest(waitS), .avs_address(adr),
        .avs_read(rdS), .avs_write(wrS), .avs_writedata(wdat));
    initial forever #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        host.access(1'b0, a, 32'h0, d);
        chk(d, exp);
    endtask
    task wr(input logic [31:0] v);
        host.access(1'b1, 8'h40, v, d);
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        for (int i = 0; i < 8; i++) rd(8'h0c + 8'(i * 4), 32'h0);
        rd(8'h11, 32'h0);
        $display("test reset done");
    endtask
    task t_view;
        wr(32'h86);
        clsVal <= 16'h0040;
        detDone <= 4'h4;
        clsDone <= 4'h2;
        tick(1);
        detDone <= 4'h0;
        clsDone <= 4'h0;
        tick(2);
        chk(sum, 5'h06);
        chk(alertN, 1'b0);
        rd(8'h10, 32'h24);
        rd(8'h10, 32'h24);
        rd(8'h14, 32'h24);
        rd(8'h10, 32'h00);
        chk(alertN, 1'b1);
        $display("test view and clear done");
    endtask
    task t_fault;
        wr(32'h0);
        disc <= 4'h8;
        stf <= 4'h1;
        ovc <= 4'h2;
        tick(1);
        disc <= 4'h0;
        stf <= 4'h0;
        tick(45);
        ovc <= 4'h0;
        lim <= 4'h4;
        tick(45);
        lim <= 4'h0;
        tick(1);
        rd(8'h18, 32'h82);
        rd(8'h20, 32'h41);
        chk(cutSeen, 32'h1);
        off <= 4'hf;
        tick(2);
        off <= 4'h0;
        tick(1);
        rd(8'h18, 32'h00);
        rd(8'h24, 32'h00);
        $display("test fault and off done");
    endtask
    task t_pair;
        wr(32'h586);
        detDone <= 4'h1;
        tick(1);
        detDone <= 4'h0;
        tick(2);
        rd(8'h10, 32'h00);
        detDone <= 4'h2;
        tick(1);
        detDone <= 4'h0;
        tick(1);
        rd(8'h14, 32'h03);
        pon <= 2'h1;
        detDone <= 4'h1;
        tick(1);
        detDone <= 4'h0;
        pon <= 2'h0;
        tick(1);
        rd(8'h14, 32'h01);
        $display("test pairing done");
    endtask
    task t_change;
        wr(32'h40);
        detDone <= 4'h8;
        tick(1);
        detDone <= 4'h0;
        tick(1);
        rd(8'h14, 32'h00);
        detValid <= 4'h8;
        detDone <= 4'h8;
        tick(1);
        detDone <= 4'h0;
        tick(1);
        rd(8'h14, 32'h08);
        $display("test change only done");
    endtask
    initial begin
        tick(10);
        nrst <= 1'b1;
        tick(2);
        t_reset;
        t_view;
        t_fault;
        t_pair;
        t_change;
        wrap_up;
    end
    initial begin
        tick(5000);
        err_total++;
        wrap_up;
    end
endmodule
`default_nettype wire
